// file: logic/adcss_consts.vh
// Constants for the channel-scan sequencer
`ifndef ADCSS_CONSTS_VH
`define ADCSS_CONSTS_VH
`define ADCSS_ADDR_GAP 4'h8
`define ADCSS_ADDR_SCAN 4'h7
`define ADCSS_ADDR_CFG0 4'h1
`define ADCSS_ADDR_CFG2 4'h3
`define ADCSS_ADDR_MUX 4'h6
`define ADCSS_ADDR_OFFS 4'h9
`define ADCSS_MUX_OFFSET 8'h88
`define ADCSS_MUX_VCM 8'hF8
`define ADCSS_MUX_SUPPLY 8'h98
`define ADCSS_MUX_TEMP 8'hDE
`define ADCSS_GAIN_THIRD 3'h0
`define ADCSS_GAIN_ONE 3'h1
`define ADCSS_RUN_SHDN 2'h0
`define ADCSS_RUN_STBY 2'h2
`define ADCSS_RUN_CONV 2'h3
`define ADCSS_WARMUP 24'h000100
`define ADCSS_DLY_LSB 20
`define ADCSS_DLY_MSB 22
`define ADCSS_RESTART_MCLK 2'h2
`define ADCSS_CH_OFFSET 4'hF
`define ADCSS_CH_VCM 4'hE
`define ADCSS_CH_SUPPLY 4'hD
`define ADCSS_CH_TEMP 4'hC
`endif

// file: logic/adcss_delay_table.v
// Inter-conversion delay code to divided-clock period count
module adcss_delay_table (
  input wire [2:0] inter_conversion_delay_code,
  output reg [9:0] delay_periods
);
  // Code 0 means no wait, else 8 shifted by code minus one
  always @* begin
    if (inter_conversion_delay_code == 3'h0) begin
      delay_periods = 10'h000;
    end else begin
      delay_periods = 10'h008 << (inter_conversion_delay_code - 3'h1);
    end
  end
endmodule

// file: logic/adcss_seq.v
// Channel-scan sequencer: monitor overrides, conversion delay, cycle gap timer
// Notes on behaviour
// - Supply channel forces code 0x98, gain third.
// - Overrides are temporary, registers read unchanged.
// - Temperature channel forces 0xDE, gain one.
// - Offset channel shorts mux output to ground.
// - Common-mode channel forces 0xF8, gain one.
// - Delay code selects 0 or 8..512 periods.
// - Delay only between conversions of one cycle.
// - Delay holds converter standby, field unchanged.
// - Mux switches to next input at delay start.
// - Continuous mode gap from 24-bit count 0x8.
// - Gap counter loads, counts down, relaunches at zero.
// - Gap above warm-up shuts converter down.
// - At count 256 converter powers up to warm.
// - Short gap keeps converter in standby.
// - Run state field reads 11 while scanning.
// - Setting writes during conversion restart it.
// - Channels converted from top mask bit down.
// - Restart takes effect two master clocks later.
// - Gap-count write during gap restarts sequence.
`include "adcss_consts.vh"
module adcss_seq #(
  parameter DIV = 4,
  parameter NCH = 16
) (
  input wire clk,
  input wire reset_n,
  input wire wr_en,
  input wire [3:0] wr_addr,
  input wire [23:0] wr_data,
  input wire rd_en,
  input wire [3:0] rd_addr,
  output reg [23:0] rd_data,
  input wire conv_done,
  output reg conv_start,
  output reg conv_abort,
  output reg [7:0] input_select_code,
  output reg [2:0] gain_code,
  output reg [1:0] run_state,
  output reg mux_short_to_ground,
  output reg [3:0] channel_id
);
  ////////////////////////////////////////////////////////////////
  // Reset release
  reg rst_a_q;
  reg rst_b_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_b_q <= rst_a_q;
    end
  end
  wire rst_n = rst_b_q;

  ////////////////////////////////////////////////////////////////
  // Divided master clock enable
  reg [7:0] div_q;
  wire divided_master_clock_en = (div_q == DIV - 1);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
    end else if (divided_master_clock_en) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register store; values stay exactly as written
  reg [7:0] cfg0_q;
  reg [23:0] scan_q;
  reg [23:0] gap_q;
  reg [7:0] mux_q;
  reg [23:0] offset_correction_q;
  reg [1:0] adc_mode_q;
  reg [2:0] gain_q;
  wire scan_mode = |scan_q[NCH-1:0];
  wire [2:0] inter_conversion_delay_code = scan_q[`ADCSS_DLY_MSB:`ADCSS_DLY_LSB];
  // Host applies its own offset correction by writing the negated value
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg0_q <= 8'h00;
      scan_q <= 24'h000000;
      gap_q <= 24'h000000;
      mux_q <= 8'h01;
      offset_correction_q <= 24'h000000;
      adc_mode_q <= 2'h0;
      gain_q <= 3'h1;
    end else if (wr_en) begin
      case (wr_addr)
        `ADCSS_ADDR_CFG0: begin
          cfg0_q <= wr_data[7:0];
          adc_mode_q <= wr_data[1:0];
        end
        `ADCSS_ADDR_CFG2: gain_q <= wr_data[5:3];
        `ADCSS_ADDR_MUX: mux_q <= wr_data[7:0];
        `ADCSS_ADDR_SCAN: scan_q <= wr_data;
        `ADCSS_ADDR_GAP: gap_q <= wr_data;
        `ADCSS_ADDR_OFFS: offset_correction_q <= wr_data;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer state
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_SYNC = 3'h1;
  localparam [2:0] S_CONV = 3'h2;
  localparam [2:0] S_DLY = 3'h3;
  localparam [2:0] S_GAP = 3'h4;
  reg [2:0] state_q;
  reg [3:0] ch_q;
  reg [23:0] cnt_q;
  reg [1:0] sync_q;
  reg long_gap_q;
  reg warm_q;
  wire [9:0] delay_periods;

  adcss_delay_table u_dly (
    .inter_conversion_delay_code(inter_conversion_delay_code),
    .delay_periods(delay_periods)
  );

  // Highest enabled channel strictly below a position, one generate per bit
  wire [NCH-1:0] below_cur;
  wire [NCH-1:0] enabled = scan_q[NCH-1:0];
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_mask
      assign below_cur[gi] = enabled[gi] && (gi < ch_q);
    end
  endgenerate
  reg [3:0] next_ch;
  reg has_next;
  reg [3:0] first_ch;
  integer k;
  // Priority from top mask bit downwards
  always @* begin
    next_ch = 4'h0;
    has_next = 1'b0;
    first_ch = 4'h0;
    for (k = 0; k < NCH; k = k + 1) begin
      if (below_cur[k]) begin
        next_ch = k[3:0];
        has_next = 1'b1;
      end
      if (enabled[k]) begin
        first_ch = k[3:0];
      end
    end
  end

  // Write-triggered restarts
  wire scanning = scan_mode && (adc_mode_q == `ADCSS_RUN_CONV) && (state_q != S_IDLE);
  wire wr_setting = wr_en && ((wr_addr == `ADCSS_ADDR_CFG0) || (wr_addr == `ADCSS_ADDR_CFG2));
  wire wr_start = wr_en && (wr_addr == `ADCSS_ADDR_CFG0) && (wr_data[1:0] == `ADCSS_RUN_CONV);
  wire wr_stop = wr_en && (wr_addr == `ADCSS_ADDR_CFG0) && (wr_data[1:0] != `ADCSS_RUN_CONV);
  wire wr_scan = wr_en && (wr_addr == `ADCSS_ADDR_SCAN);
  wire wr_gap_in_gap = wr_en && (wr_addr == `ADCSS_ADDR_GAP) && (state_q == S_GAP);
  wire wr_dly_in_conv = wr_scan && (state_q == S_CONV);
  wire full_restart = (wr_start && (state_q == S_IDLE)) || wr_gap_in_gap
    || (wr_scan && (state_q != S_GAP) && (state_q != S_IDLE));
  wire conv_restart = (wr_setting && !wr_stop && (state_q == S_CONV));
  wire continuous = (cfg0_q[7:6] == 2'h3);

  // Main sequencing process
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      ch_q <= 4'h0;
      cnt_q <= 24'h000000;
      sync_q <= 2'h0;
      long_gap_q <= 1'b0;
      warm_q <= 1'b0;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      if (wr_stop && (state_q != S_IDLE)) begin
        state_q <= S_IDLE;
        conv_abort <= 1'b1;
      end else if (full_restart && scan_mode) begin
        // Restart held back two master clocks to stay aligned
        state_q <= S_SYNC;
        ch_q <= first_ch;
        sync_q <= `ADCSS_RESTART_MCLK;
        conv_abort <= (state_q == S_CONV);
      end else if (conv_restart || wr_dly_in_conv) begin
        state_q <= S_SYNC;
        sync_q <= `ADCSS_RESTART_MCLK;
        conv_abort <= 1'b1;
      end else begin
        case (state_q)
          S_IDLE: begin
          end
          S_SYNC: begin
            if (sync_q == 2'h1) begin
              state_q <= S_CONV;
              conv_start <= 1'b1;
            end
            sync_q <= sync_q - 2'h1;
          end
          S_CONV: begin
            if (conv_done) begin
              if (has_next) begin
                // Mux moves to next input now, giving the delay to settle
                ch_q <= next_ch;
                if (delay_periods == 10'h000) begin
                  // One sync cycle lets the new mux code land in the same cycle as the start
                  state_q <= S_SYNC;
                  sync_q <= 2'h1;
                end else begin
                  state_q <= S_DLY;
                  cnt_q <= {14'h0000, delay_periods};
                end
              end else if (continuous) begin
                state_q <= S_GAP;
                ch_q <= first_ch;
                cnt_q <= gap_q;
                long_gap_q <= (gap_q > `ADCSS_WARMUP);
                warm_q <= 1'b0;
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
          S_DLY: begin
            if (divided_master_clock_en) begin
              if (cnt_q == 24'h000001) begin
                state_q <= S_CONV;
                conv_start <= 1'b1;
              end
              cnt_q <= cnt_q - 24'h000001;
            end
          end
          S_GAP: begin
            if (cnt_q == 24'h000000) begin
              state_q <= S_CONV;
              conv_start <= 1'b1;
            end else if (divided_master_clock_en) begin
              if (cnt_q == `ADCSS_WARMUP) begin
                warm_q <= 1'b1;
              end
              cnt_q <= cnt_q - 24'h000001;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Per-conversion analog settings; stored fields never touched
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_select_code <= 8'h01;
      gain_code <= 3'h1;
      mux_short_to_ground <= 1'b0;
      channel_id <= 4'h0;
    end else begin
      channel_id <= ch_q;
      mux_short_to_ground <= 1'b0;
      gain_code <= gain_q;
      if (!scan_mode) begin
        input_select_code <= mux_q;
      end else begin
        case (ch_q)
          `ADCSS_CH_OFFSET: begin
            input_select_code <= `ADCSS_MUX_OFFSET;
            mux_short_to_ground <= 1'b1;
          end
          `ADCSS_CH_VCM: begin
            input_select_code <= `ADCSS_MUX_VCM;
            gain_code <= `ADCSS_GAIN_ONE;
          end
          `ADCSS_CH_SUPPLY: begin
            input_select_code <= `ADCSS_MUX_SUPPLY;
            gain_code <= `ADCSS_GAIN_THIRD;
          end
          `ADCSS_CH_TEMP: begin
            input_select_code <= `ADCSS_MUX_TEMP;
            gain_code <= `ADCSS_GAIN_ONE;
          end
          default: begin
            // Differential pairs for 8..11, single-ended against ground below
            if (ch_q[3]) begin
              input_select_code <= {1'b0, ch_q[1:0], 1'b0, 1'b0, ch_q[1:0], 1'b1} + 8'h00;
            end else begin
              input_select_code <= {1'b0, ch_q[2:0], 4'h8};
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Internal power state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_state <= `ADCSS_RUN_SHDN;
    end else begin
      case (state_q)
        S_CONV, S_SYNC: run_state <= `ADCSS_RUN_CONV;
        S_DLY: run_state <= `ADCSS_RUN_STBY;
        S_GAP: begin
          if (!long_gap_q) begin
            run_state <= `ADCSS_RUN_STBY;
          end else if (warm_q) begin
            run_state <= `ADCSS_RUN_CONV;
          end else begin
            run_state <= `ADCSS_RUN_SHDN;
          end
        end
        default: run_state <= adc_mode_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register readback; run-state field shows 11 whenever scanning
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 24'h000000;
    end else if (rd_en) begin
      case (rd_addr)
        `ADCSS_ADDR_CFG0: rd_data <= {16'h0000, cfg0_q[7:2], (scanning ? `ADCSS_RUN_CONV : cfg0_q[1:0])};
        `ADCSS_ADDR_CFG2: rd_data <= {18'h00000, gain_q, 3'h0};
        `ADCSS_ADDR_MUX: rd_data <= {16'h0000, mux_q};
        `ADCSS_ADDR_SCAN: rd_data <= scan_q;
        `ADCSS_ADDR_GAP: rd_data <= gap_q;
        `ADCSS_ADDR_OFFS: rd_data <= offset_correction_q;
        default: rd_data <= 24'h000000;
      endcase
    end
  end
endmodule

// file: verification/adcss_seq_properties.sv
// Port-level checker for the channel-scan sequencer
`include "adcss_consts.vh"
module adcss_seq_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [23:0] wr_data,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic [7:0] input_select_code,
  input wire logic [2:0] gain_code,
  input wire logic mux_short_to_ground,
  input wire logic [3:0] channel_id
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mask_q;
  // Mirror of the scan mask, so a start can be tied to an enabled channel
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) mask_q <= 16'h0000;
    else if (wr_en && wr_addr == `ADCSS_ADDR_SCAN) mask_q <= wr_data[15:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_start_wr;
    wr_en && wr_addr == `ADCSS_ADDR_CFG0 && wr_data[1:0] == 2'h3 && mask_q != 16'h0000;
  endsequence
  sequence s_ch(logic [3:0] ch);
    conv_start && channel_id == ch;
  endsequence
  ///////////////////////////////////////////////////////////////////////////
  a_supply_override: assert property (s_ch(`ADCSS_CH_SUPPLY) |-> input_select_code == 8'h98 && gain_code == 3'h0)
    else $error("supply channel override wrong");
  a_temp_override: assert property (s_ch(`ADCSS_CH_TEMP) |-> input_select_code == 8'hDE && gain_code == 3'h1)
    else $error("temperature channel override wrong");
  a_vcm_override: assert property (s_ch(`ADCSS_CH_VCM) |-> input_select_code == 8'hF8 && gain_code == 3'h1)
    else $error("common-mode channel override wrong");
  a_offset_short: assert property (s_ch(`ADCSS_CH_OFFSET) |-> mux_short_to_ground)
    else $error("offset channel not shorted");
  a_restart_two: assert property (s_start_wr |-> ##3 conv_start)
    else $error("start not three cycles after write");
  a_enabled_only: assert property (conv_start && mask_q != 16'h0000 |-> mask_q[channel_id])
    else $error("started channel not enabled");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  a_abort_pulse: assert property (conv_abort |=> !conv_abort[*2])
    else $error("abort pulse repeated");
endmodule
bind adcss_seq adcss_seq_properties u_props (.clk(clk), .reset_n(reset_n), .wr_en(wr_en), .wr_addr(wr_addr),
  .wr_data(wr_data), .conv_start(conv_start), .conv_abort(conv_abort), .input_select_code(input_select_code),
  .gain_code(gain_code), .mux_short_to_ground(mux_short_to_ground), .channel_id(channel_id));

// file: verification/adcss_conv_model.sv
// Converter stand-in that answers each start after a fixed latency
module adcss_conv_model #(parameter int LAT = 20) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic conv_start,
  input wire logic conv_abort,
  output logic conv_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_q;
  // An abort drops the pending result; a restarted conversion must not report early
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= (cnt_q == 1);
      if (conv_start) cnt_q <= LAT;
      else if (conv_abort || cnt_q == 0) cnt_q <= 0;
      else cnt_q <= cnt_q - 1;
    end
  end
endmodule

// file: verification/tb.sv
// Self-checking testbench for the channel-scan sequencer
`include "adcss_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 4;
  logic clk = 0, reset_n = 0, wr_en = 0, rd_en = 0;
  logic [3:0] wr_addr = 4'h0, rd_addr = 4'h0, channel_id;
  logic [23:0] wr_data = 24'h0, rd_data;
  logic conv_done, conv_start, conv_abort, mux_short_to_ground;
  logic [7:0] input_select_code;
  logic [2:0] gain_code;
  logic [1:0] run_state;
  int failures = 0, comparisons = 0, cyc = 0;
  adcss_seq #(.DIV(DIV), .NCH(16)) dut (.clk(clk), .reset_n(reset_n), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .conv_done(conv_done),
    .conv_start(conv_start), .conv_abort(conv_abort), .input_select_code(input_select_code),
    .gain_code(gain_code), .run_state(run_state), .mux_short_to_ground(mux_short_to_ground),
    .channel_id(channel_id));
  adcss_conv_model #(.LAT(20)) u_conv (.clk(clk), .reset_n(reset_n), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_done(conv_done));
  initial forever #50 clk = ~clk;
  task automatic conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the roughly 8000 cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  task automatic chk(string what, logic [23:0] seen, logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [23:0] d);
    @(negedge clk);
    wr_en = 1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_en = 0;
  endtask
  task automatic rd(logic [3:0] a, output logic [23:0] d);
    @(negedge clk);
    rd_en = 1;
    rd_addr = a;
    @(negedge clk);
    rd_en = 0;
    d = rd_data;
  endtask
  // Counts falling edges until start (w=0) or done (w=1), bounded by lim
  task automatic waitsig(bit w, output int n, input int lim);
    n = 0;
    while ((w ? conv_done : conv_start) !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  ///////////////////////////////////////////////////////////////////////////
  task automatic t_monitor;
    logic [7:0] mux[4] = '{8'h88, 8'hF8, 8'h98, 8'hDE};
    logic [2:0] gn[4] = '{3'h5, 3'h1, 3'h0, 3'h1};
    logic [23:0] d;
    int n;
    wr(`ADCSS_ADDR_CFG2, 24'h000028);
    wr(`ADCSS_ADDR_SCAN, 24'h00F000);
    wr(`ADCSS_ADDR_CFG0, 24'h000003);
    for (int i = 0; i < 4; i++) begin
      waitsig(0, n, 99);
      chk("channel", channel_id, 24'(15 - i));
      chk("mux", input_select_code, mux[i]);
      chk("gain", gain_code, gn[i]);
      chk("short", mux_short_to_ground, i == 0);
      if (i == 1) rd(`ADCSS_ADDR_CFG0, d);
      if (i == 1) chk("mode read", d[1:0], 2'h3);
      waitsig(1, n, 99);
    end
    rd(`ADCSS_ADDR_CFG2, d);
    chk("gain reg", d[5:3], 3'h5);
    $display("test monitor done");
  endtask
  task automatic t_delay;
    int n, m, e;
    for (int c = 0; c < 8; c++) begin
      e = (c == 0) ? 0 : (4 << c) * DIV;
      wr(`ADCSS_ADDR_SCAN, (24'(c) << 20) | 24'h000003);
      wr(`ADCSS_ADDR_CFG0, 24'h000003);
      waitsig(0, n, 99);
      chk("first start", n, 2);
      waitsig(1, n, 99);
      m = 0;
      if (c != 0) begin
        repeat (2) @(negedge clk);
        m = 2;
        chk("next ch", channel_id, 0);
        chk("delay state", run_state, `ADCSS_RUN_STBY);
      end
      waitsig(0, n, 3000);
      if (c == 0) chk("delay", n, 2);
      else chk("delay", n + m >= e - DIV + 2 && n + m <= e + 1, 1'b1);
      waitsig(1, n, 99);
    end
    waitsig(0, n, 2100);
    chk("tail start", n, 2100);
    $display("test delay done");
  endtask
  task automatic t_restart;
    logic [23:0] d;
    int n;
    wr(`ADCSS_ADDR_SCAN, 24'h000100);
    wr(`ADCSS_ADDR_CFG0, 24'h000003);
    waitsig(0, n, 99);
    repeat (5) @(negedge clk);
    wr(`ADCSS_ADDR_CFG2, 24'h000008);
    waitsig(0, n, 99);
    chk("restart", n, 2);
    wr(`ADCSS_ADDR_OFFS, 24'hFFFF10);
    rd(`ADCSS_ADDR_OFFS, d);
    chk("offset reg", d, 24'hFFFF10);
    waitsig(1, n, 99);
    $display("test restart done");
  endtask
  task automatic t_gap;
    logic [23:0] d;
    int n;
    wr(`ADCSS_ADDR_GAP, 24'h00012C);
    wr(`ADCSS_ADDR_SCAN, 24'h000001);
    wr(`ADCSS_ADDR_CFG0, 24'h0000C3);
    waitsig(0, n, 99);
    waitsig(1, n, 99);
    repeat (4) @(negedge clk);
    rd(`ADCSS_ADDR_CFG0, d);
    chk("gap mode read", d[1:0], 2'h3);
    repeat (160) @(negedge clk);
    chk("gap shutdown", run_state, `ADCSS_RUN_SHDN);
    repeat (30) @(negedge clk);
    chk("warm up", run_state != `ADCSS_RUN_SHDN, 1'b1);
    waitsig(0, n, 2000);
    chk("gap", n + 196 >= 300 * DIV - 1 && n + 196 <= 300 * DIV + 2, 1'b1);
    waitsig(1, n, 99);
    wr(`ADCSS_ADDR_GAP, 24'h00000A);
    waitsig(0, n, 99);
    chk("gap restart", n, 2);
    waitsig(1, n, 99);
    repeat (4) @(negedge clk);
    chk("short gap", run_state, `ADCSS_RUN_STBY);
    wr(`ADCSS_ADDR_CFG0, 24'h000000);
    $display("test gap done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1;
    repeat (4) @(negedge clk);
    t_monitor();
    t_delay();
    t_restart();
    t_gap();
    conclude();
  end
endmodule
